/* verilog/exec_core_pkg.sv */
// constants, opcodes and ALU function codes for the byte execution core
package exec_core_pkg;
	// ----------------------------------------
	// widths
	// ----------------------------------------
	localparam int ADDR_W = 12;
	localparam int DIRECT_W = 10;
	localparam int DATA_W = 8;
	localparam int IADDR_W = 11;
	localparam int PC_W = 12;
	localparam int STACK_DEPTH = 16;
	localparam int SP_W = 5;
	localparam int NIB_W = 4;
	localparam int SIGN_BIT = 7;
	localparam int LOW_BYTE_HI = 7;
	localparam int HIGH_ADDR_LO = 8;
	localparam logic [SP_W-1:0] SP_FULL = 5'h10;
	localparam logic [SP_W-1:0] SP_ONE = 5'h01;
	localparam logic [PC_W-1:0] PC_ONE = 12'h001;
	localparam logic [ADDR_W-1:0] ADDR_ONE = 12'h001;
	localparam logic [PC_W-1:0] PC_RESET = 12'h000;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 12'h000;
	localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
	localparam logic [DATA_W-1:0] BYTE_ONES = 8'hff;
	localparam logic [DATA_W:0] WIDE_ONE = 9'h001;

	// ----------------------------------------
	// instruction opcodes (top four bits of the word)
	// ----------------------------------------
	typedef enum logic [3:0] {
		OP_NOP = 4'h0,
		OP_DIRECT_ADDR = 4'h1,
		OP_ADDR_LOW = 4'h2,
		OP_ADDR_HIGH = 4'h3,
		OP_ADDR_INC = 4'h4,
		OP_BUS_SEL = 4'h5,
		OP_BRANCH = 4'h6,
		OP_CALL = 4'h7,
		OP_RETURN = 4'h8,
		OP_BR_TRUE = 4'h9,
		OP_BR_FALSE = 4'ha,
		OP_PAGE = 4'hb,
		OP_ALU_FUNC = 4'hc,
		OP_B_LOAD = 4'hd
	} opcode_e;

	// data-bus sources
	typedef enum logic [1:0] {
		SRC_LITERAL = 2'h0,
		SRC_MEMORY = 2'h1,
		SRC_UNIVERSAL = 2'h2,
		SRC_B = 2'h3
	} bus_src_e;

	// branch conditions
	typedef enum logic [2:0] {
		COND_SIGN = 3'h0,
		COND_CARRY = 3'h1,
		COND_EQUAL = 3'h2,
		COND_BUS_BIT = 3'h3,
		COND_STACK = 3'h4
	} cond_e;

	// B-register capture modes
	typedef enum logic [1:0] {
		BLD_FULL = 2'h0,
		BLD_HIGH = 2'h1,
		BLD_LOW = 2'h2,
		BLD_CLEAR = 2'h3
	} b_load_e;

	// ALU functions
	typedef enum logic [4:0] {
		F_D = 5'h00,
		F_D_N = 5'h01,
		F_B = 5'h02,
		F_B_N = 5'h03,
		F_ONES = 5'h04,
		F_ZERO = 5'h05,
		F_OR = 5'h06,
		F_OR_BN = 5'h07,
		F_OR_DN = 5'h08,
		F_OR_DN_BN = 5'h09,
		F_D_PLUS_B = 5'h0a,
		F_D_PLUS_B_1 = 5'h0b,
		F_D_PLUS_1 = 5'h0c,
		F_D_MINUS_B = 5'h0d,
		F_D_MINUS_B_1 = 5'h0e,
		F_D_MINUS_1 = 5'h0f,
		F_D_PLUS_D = 5'h10,
		F_D_PLUS_D_1 = 5'h11
	} alu_func_e;
endpackage : exec_core_pkg

/* verilog/return_stack.sv */
// sixteen-entry return-address memory with registered read data
`timescale 1ns/10ps
module return_stack
(
	input wire logic clk_sys,
	input wire logic clk_en,
	input wire logic wr_en,
	input wire logic [3:0] wr_addr,
	input wire logic [exec_core_pkg::PC_W-1:0] wr_data,
	input wire logic [3:0] rd_addr,
	output logic [exec_core_pkg::PC_W-1:0] rd_data
);
	logic [exec_core_pkg::PC_W-1:0] mem [exec_core_pkg::STACK_DEPTH];

	// write port
	always_ff @(posedge clk_sys)
	begin
		if (clk_en && wr_en)
		begin
			mem[wr_addr] <= wr_data;
		end
	end

	// registered read port
	always_ff @(posedge clk_sys)
	begin
		if (clk_en)
		begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule : return_stack

/* verilog/exec_core.sv */
// execution core: address register, data bus, branches, stack and ALU
`timescale 1ns/10ps

module exec_core
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic [15:0] instr_word,
	output logic [exec_core_pkg::PC_W-1:0] instr_addr,
	input wire logic [exec_core_pkg::DATA_W-1:0] mem_rdata,
	input wire logic [exec_core_pkg::DATA_W-1:0] literal_value,
	input wire logic [exec_core_pkg::DATA_W-1:0] universal_value,
	output logic [exec_core_pkg::ADDR_W-1:0] data_addr,
	output logic [exec_core_pkg::DATA_W-1:0] data_bus,
	output logic [exec_core_pkg::DATA_W-1:0] alu_reg,
	output logic carry_flag,
	output logic stack_overflow,
	output logic page_select
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef enum logic [1:0] {
		ST_FETCH,
		ST_OPERAND
	} phase_e;

	phase_e phase_reg;
	logic [exec_core_pkg::PC_W-1:0] pc_reg;
	logic [exec_core_pkg::ADDR_W-1:0] addr_reg;
	exec_core_pkg::bus_src_e src_reg;
	logic [exec_core_pkg::DATA_W-1:0] b_reg;
	exec_core_pkg::alu_func_e func_reg;
	logic carry_reg;
	logic ovf_reg;
	logic page_reg;
	logic [exec_core_pkg::SP_W-1:0] sp_reg;
	logic [3:0] pend_op_reg;
	logic [2:0] pend_cond_reg;
	logic [2:0] pend_bit_reg;
	logic ret_armed_reg;
	logic [exec_core_pkg::DATA_W-1:0] bus_next;
	logic [exec_core_pkg::DATA_W:0] alu_sum;
	logic [exec_core_pkg::DATA_W-1:0] alu_f;
	logic cond_val;
	logic take_branch;
	logic [exec_core_pkg::PC_W-1:0] target;
	logic [exec_core_pkg::PC_W-1:0] stack_top;
	logic [3:0] opcode;
	logic push_now;
	logic [3:0] push_idx;
	logic [3:0] top_idx;
	logic [exec_core_pkg::PC_W-1:0] ret_addr;

	assign opcode = instr_word[15:12];
	assign target = {page_reg, instr_word[exec_core_pkg::IADDR_W-1:0]};
	assign push_now = clk_en && phase_reg == ST_OPERAND
		&& pend_op_reg == exec_core_pkg::OP_CALL && sp_reg != exec_core_pkg::SP_FULL;
	assign push_idx = sp_reg[3:0];
	assign top_idx = sp_reg[3:0] - 4'h1;
	assign ret_addr = pc_reg + exec_core_pkg::PC_ONE;

	// ----------------------------------------
	// return-address memory
	// ----------------------------------------
	return_stack u_stack
	(
		.clk_sys(clk_sys),
		.clk_en(clk_en),
		.wr_en(push_now),
		.wr_addr(push_idx),
		.wr_data(ret_addr),
		.rd_addr(top_idx),
		.rd_data(stack_top)
	);

	// data bus source mux
	always_comb
	begin
		case (src_reg)
			exec_core_pkg::SRC_LITERAL: bus_next = literal_value;
			exec_core_pkg::SRC_MEMORY: bus_next = mem_rdata;
			exec_core_pkg::SRC_UNIVERSAL: bus_next = universal_value;
			default: bus_next = b_reg;
		endcase
	end

	// alu function decode
	always_comb
	begin
		alu_sum = {1'b0, exec_core_pkg::BYTE_ZERO};
		alu_f = exec_core_pkg::BYTE_ZERO;
		case (func_reg)
			exec_core_pkg::F_D: alu_f = bus_next;
			exec_core_pkg::F_D_N: alu_f = ~bus_next;
			exec_core_pkg::F_B: alu_f = b_reg;
			exec_core_pkg::F_B_N: alu_f = ~b_reg;
			exec_core_pkg::F_ONES: alu_f = exec_core_pkg::BYTE_ONES;
			exec_core_pkg::F_OR: alu_f = bus_next | b_reg;
			exec_core_pkg::F_OR_BN: alu_f = bus_next | ~b_reg;
			exec_core_pkg::F_OR_DN: alu_f = ~bus_next | b_reg;
			exec_core_pkg::F_OR_DN_BN: alu_f = ~bus_next | ~b_reg;
			exec_core_pkg::F_D_PLUS_B: alu_sum = {1'b0, bus_next} + {1'b0, b_reg};
			exec_core_pkg::F_D_PLUS_B_1:
				alu_sum = {1'b0, bus_next} + {1'b0, b_reg} + exec_core_pkg::WIDE_ONE;
			exec_core_pkg::F_D_PLUS_1: alu_sum = {1'b0, bus_next} + exec_core_pkg::WIDE_ONE;
			exec_core_pkg::F_D_MINUS_B: alu_sum = {1'b0, bus_next} - {1'b0, b_reg};
			exec_core_pkg::F_D_MINUS_B_1:
				alu_sum = {1'b0, bus_next} - {1'b0, b_reg} - exec_core_pkg::WIDE_ONE;
			exec_core_pkg::F_D_MINUS_1: alu_sum = {1'b0, bus_next} - exec_core_pkg::WIDE_ONE;
			exec_core_pkg::F_D_PLUS_D: alu_sum = {1'b0, bus_next} + {1'b0, bus_next};
			exec_core_pkg::F_D_PLUS_D_1:
				alu_sum = {1'b0, bus_next} + {1'b0, bus_next} + exec_core_pkg::WIDE_ONE;
			default: alu_f = exec_core_pkg::BYTE_ZERO;
		endcase
		if (func_reg >= exec_core_pkg::F_D_PLUS_B)
		begin
			alu_f = alu_sum[exec_core_pkg::DATA_W-1:0];
		end
	end

	// branch condition select
	always_comb
	begin
		case (pend_cond_reg)
			exec_core_pkg::COND_SIGN: cond_val = b_reg[exec_core_pkg::SIGN_BIT];
			exec_core_pkg::COND_CARRY: cond_val = carry_reg;
			exec_core_pkg::COND_EQUAL: cond_val = alu_f == exec_core_pkg::BYTE_ONES;
			exec_core_pkg::COND_BUS_BIT: cond_val = bus_next[pend_bit_reg];
			exec_core_pkg::COND_STACK: cond_val = ovf_reg;
			default: cond_val = 1'b0;
		endcase
		take_branch = (pend_op_reg == exec_core_pkg::OP_BR_TRUE) ? cond_val : !cond_val;
	end

	// ----------------------------------------
	// sequencing and program counter
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			phase_reg <= ST_FETCH;
			pc_reg <= exec_core_pkg::PC_RESET;
			pend_op_reg <= exec_core_pkg::OP_NOP;
			pend_cond_reg <= exec_core_pkg::COND_SIGN;
			pend_bit_reg <= 3'h0;
			ret_armed_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			if (phase_reg == ST_OPERAND)
			begin
				phase_reg <= ST_FETCH;
				case (pend_op_reg)
					exec_core_pkg::OP_BRANCH: pc_reg <= target;
					exec_core_pkg::OP_CALL: pc_reg <= target;
					exec_core_pkg::OP_RETURN:
					begin
						pc_reg <= pc_reg + exec_core_pkg::PC_ONE;
						ret_armed_reg <= 1'b1;
					end
					default: pc_reg <= take_branch ? target : pc_reg + exec_core_pkg::PC_ONE;
				endcase
			end
			else if (ret_armed_reg)
			begin
				ret_armed_reg <= 1'b0;
				pc_reg <= stack_top;
			end
			else
			begin
				pc_reg <= pc_reg + exec_core_pkg::PC_ONE;
				pend_op_reg <= opcode;
				pend_cond_reg <= instr_word[5:3];
				pend_bit_reg <= instr_word[2:0];
				if (opcode == exec_core_pkg::OP_BRANCH || opcode == exec_core_pkg::OP_CALL
					|| opcode == exec_core_pkg::OP_RETURN || opcode == exec_core_pkg::OP_BR_TRUE
					|| opcode == exec_core_pkg::OP_BR_FALSE)
				begin
					phase_reg <= ST_OPERAND;
				end
			end
		end
	end

	// stack pointer and overflow flag
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sp_reg <= 5'h00;
			ovf_reg <= 1'b0;
		end
		else if (clk_en && phase_reg == ST_OPERAND && pend_op_reg == exec_core_pkg::OP_CALL)
		begin
			if (sp_reg == exec_core_pkg::SP_FULL)
			begin
				ovf_reg <= 1'b1;
			end
			else
			begin
				sp_reg <= sp_reg + exec_core_pkg::SP_ONE;
			end
		end
		else if (clk_en && ret_armed_reg && phase_reg == ST_FETCH && sp_reg != 5'h00)
		begin
			sp_reg <= sp_reg - exec_core_pkg::SP_ONE;
		end
	end

	// page latch, held until the next page instruction
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			page_reg <= 1'b0;
		end
		else if (clk_en && phase_reg == ST_FETCH && opcode == exec_core_pkg::OP_PAGE)
		begin
			page_reg <= instr_word[0];
		end
	end

	// ----------------------------------------
	// single-cycle instructions
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			addr_reg <= exec_core_pkg::ADDR_RESET;
			src_reg <= exec_core_pkg::SRC_LITERAL;
			func_reg <= exec_core_pkg::F_ZERO;
		end
		else if (clk_en && phase_reg == ST_FETCH) // also the slot after a return
		begin
			case (opcode)
				exec_core_pkg::OP_DIRECT_ADDR:
					addr_reg[exec_core_pkg::DIRECT_W-1:0] <= instr_word[9:0];
				exec_core_pkg::OP_ADDR_LOW:
					addr_reg[exec_core_pkg::LOW_BYTE_HI:0] <= bus_next;
				exec_core_pkg::OP_ADDR_HIGH:
					addr_reg[exec_core_pkg::ADDR_W-1:exec_core_pkg::HIGH_ADDR_LO]
						<= bus_next[exec_core_pkg::NIB_W-1:0];
				exec_core_pkg::OP_ADDR_INC: addr_reg <= addr_reg + exec_core_pkg::ADDR_ONE;
				exec_core_pkg::OP_BUS_SEL: src_reg <= exec_core_pkg::bus_src_e'(instr_word[1:0]);
				exec_core_pkg::OP_ALU_FUNC: func_reg <= exec_core_pkg::alu_func_e'(instr_word[4:0]);
				default: addr_reg <= addr_reg;
			endcase
		end
	end

	// B register capture and carry
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			b_reg <= exec_core_pkg::BYTE_ZERO;
			carry_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			carry_reg <= alu_sum[exec_core_pkg::DATA_W];
			if (phase_reg == ST_FETCH && opcode == exec_core_pkg::OP_B_LOAD)
			begin
				case (exec_core_pkg::b_load_e'(instr_word[1:0]))
					exec_core_pkg::BLD_FULL: b_reg <= alu_f;
					exec_core_pkg::BLD_HIGH: b_reg[7:4] <= alu_f[7:4];
					exec_core_pkg::BLD_LOW: b_reg[3:0] <= alu_f[3:0];
					default: b_reg <= exec_core_pkg::BYTE_ZERO;
				endcase
			end
		end
	end

	// registered outputs
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			data_bus <= exec_core_pkg::BYTE_ZERO;
			carry_flag <= 1'b0;
			stack_overflow <= 1'b0;
		end
		else if (clk_en)
		begin
			data_bus <= bus_next;
			carry_flag <= carry_reg;
			stack_overflow <= ovf_reg;
		end
	end

	// outputs read straight from their state flops, fetch address without lag
	assign data_addr = addr_reg;
	assign instr_addr = pc_reg;
	assign alu_reg = b_reg;
	assign page_select = page_reg;
endmodule : exec_core

/* testbench/exec_core_props.sv */
// port-level assertions for the execution core
`timescale 1ns/10ps
module exec_core_props
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic [15:0] instr_word,
	input wire logic [11:0] instr_addr,
	input wire logic [7:0] mem_rdata,
	input wire logic [7:0] literal_value,
	input wire logic [7:0] universal_value,
	input wire logic [11:0] data_addr,
	input wire logic [7:0] data_bus,
	input wire logic [7:0] alu_reg,
	input wire logic carry_flag,
	input wire logic stack_overflow,
	input wire logic page_select
);
	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);
	// top address bits move only by the nibble load or a carry
	AST_ADDR_TOP: assert property ($changed(data_addr[11:10]) |->
		data_addr[11:10] == $past(data_bus[3:2]) || data_addr == $past(data_addr) + 12'h001)
		else $error("address top bits changed without cause");
	// low byte comes from the bus, an immediate or an increment
	AST_ADDR_LOW: assert property ($changed(data_addr[7:0]) |->
		data_addr[7:0] == $past(data_bus) || data_addr[7:0] == $past(instr_word[7:0])
		|| data_addr == $past(data_addr) + 12'h001)
		else $error("address low byte changed without cause");
	AST_PAGE_SRC: assert property ($changed(page_select) |->
		$past(instr_word[15:12]) == 4'hb && page_select == $past(instr_word[0]))
		else $error("page changed without a page instruction");
	AST_OVF_KEEP: assert property (stack_overflow |=> stack_overflow)
		else $error("overflow flag lost");
	AST_B_CLEAR: assert property (
		clk_en && instr_word == 16'hd003 |-> ##[1:2] alu_reg == 8'h00)
		else $error("b register clear not seen");
	// a stalled cycle leaves both addresses, the bus, alu_reg, carry_flag and page_select alone
	AST_HOLD_ADDR: assert property (!clk_en |=> $stable(data_addr) && $stable(instr_addr))
		else $error("address moved while stalled");
	AST_HOLD_ALU: assert property (!clk_en |=> $stable(alu_reg) && $stable(carry_flag))
		else $error("alu state moved while stalled");
	AST_HOLD_BUS: assert property (!clk_en |=> $stable(data_bus) && $stable(page_select))
		else $error("bus moved while stalled");
	C_OVF: cover property ($rose(stack_overflow));
	C_PAGE: cover property ($rose(page_select));
	C_CARRY: cover property ($rose(carry_flag));
endmodule : exec_core_props

/* testbench/exec_mem_model.sv */
// behavioural instruction and data memories facing the execution core
`timescale 1ns/10ps
module exec_mem_model
(
	input wire logic [11:0] instr_addr,
	output logic [15:0] instr_word,
	input wire logic [11:0] data_addr,
	output logic [7:0] mem_rdata
);
	bit [15:0] imem [4096];
	bit [7:0] dmem [4096];
	// word at the fetch address, operands follow in order
	assign instr_word = imem[instr_addr];
	// data word at the address register
	assign mem_rdata = dmem[data_addr];
endmodule : exec_mem_model

/* testbench/test_byte_cpu_execution_core.sv */
// self-checking bench for the execution core with its memories
`timescale 1ns/10ps
module test_byte_cpu_execution_core;
	typedef struct {int sel; logic [11:0] val;} note_s;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic clk_en = 1'b1;
	logic running = 1'b0;
	logic [7:0] literal_value = 8'h00;
	logic [7:0] universal_value = 8'h00;
	logic [15:0] instr_word;
	logic [11:0] instr_addr, data_addr, seen;
	logic [7:0] mem_rdata, data_bus, alu_reg, lit;
	logic carry_flag, stack_overflow, page_select;
	int miscompares = 0;
	int checks = 0;
	note_s notes[$];
	note_s n;
	event probe;
	// ----------------------------------------
	// design, memories, clock
	// ----------------------------------------
	exec_core DUT (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .instr_word(instr_word),
		.instr_addr(instr_addr), .mem_rdata(mem_rdata), .literal_value(literal_value),
		.universal_value(universal_value), .data_addr(data_addr), .data_bus(data_bus),
		.alu_reg(alu_reg), .carry_flag(carry_flag), .stack_overflow(stack_overflow),
		.page_select(page_select));
	exec_mem_model mem (.instr_addr(instr_addr), .instr_word(instr_word),
		.data_addr(data_addr), .mem_rdata(mem_rdata));
	always #10 clk_sys = ~clk_sys;
	// random stalls while a program runs
	always @(negedge clk_sys)
		clk_en <= running ? $urandom_range(3) != 0 : 1'b1;
	// oldest note against the output it names
	always @(probe)
		while (notes.size() > 0)
		begin
			n = notes.pop_front();
			seen = n.sel == 0 ? data_addr : n.sel == 1 ? {4'h0, data_bus} : n.sel == 2 ?
				{4'h0, alu_reg} : n.sel == 3 ? {11'h000, stack_overflow} : n.sel == 4 ?
				{11'h000, page_select} : n.sel == 5 ? {11'h000, carry_flag} :
				{instr_addr[11:2], 2'b00};
			compare(seen, n.val);
		end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic compare(input logic [11:0] got, input logic [11:0] exp);
		checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("ERROR %0t: seen %h expected %h", $time, got, exp);
		end
	endtask : compare
	task automatic note(input int sel, input logic [11:0] val);
		notes.push_back('{sel, val});
	endtask : note
	function automatic logic [15:0] cw(input logic [3:0] op, input logic [2:0] c,
		input logic [2:0] b);
		return {op, 6'h00, c, b};
	endfunction : cw
	function automatic logic [7:0] alu(input logic [4:0] f, input logic [7:0] d,
		input logic [7:0] b);
		case (f)
			5'h00: return d;
			5'h01: return ~d;
			5'h02: return b;
			5'h03: return ~b;
			5'h04: return 8'hff;
			5'h05: return 8'h00;
			5'h06: return d | b;
			5'h07: return d | ~b;
			5'h08: return ~d | b;
			5'h09: return ~d | ~b;
			5'h0a: return d + b;
			5'h0b: return d + b + 8'h01;
			5'h0c: return d + 8'h01;
			5'h0d: return d - b;
			5'h0e: return d - b - 8'h01;
			5'h0f: return d - 8'h01;
			5'h10: return d + d;
			5'h11: return d + d + 8'h01;
			default: return 8'h00;
		endcase
	endfunction : alu
	// load a program, reset, run it to its halt loop, then probe
	task automatic run(input logic [15:0] p[$]);
		foreach (mem.imem[i])
			mem.imem[i] = 16'h0000;
		foreach (p[k])
			mem.imem[k] = p[k];
		mem.imem[64] = 16'h1055;
		mem.imem[65] = 16'h6000;
		mem.imem[66] = 16'h0041;
		mem.imem[12'hff0] = 16'h1077;
		mem.imem[12'hff1] = 16'h6000;
		mem.imem[12'hff2] = 16'h07f1;
		reset_n = 1'b0;
		repeat (5) @(negedge clk_sys);
		reset_n = 1'b1;
		running = 1'b1;
		repeat (400) @(negedge clk_sys);
		running = 1'b0;
		@(negedge clk_sys);
		-> probe;
		@(negedge clk_sys);
	endtask : run
	// branch to 64 or fall through; the marker tells which
	task automatic branch(input logic [15:0] pre[$], input logic [15:0] op, input logic taken);
		pre.push_back(op);
		pre.push_back(16'h0040);
		pre.push_back(16'h10aa);
		pre.push_back(16'h6000);
		pre.push_back(16'(pre.size() - 1));
		note(0, taken ? 12'h055 : 12'h0aa);
		run(pre);
	endtask : branch
	task automatic wrap_up();
		if (miscompares == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : wrap_up
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial
	begin
		int k;
		logic [4:0] f;
		logic [1:0] m;
		logic [9:0] d;
		logic [7:0] r, b, uni;
		logic [11:0] a;
		logic [15:0] pre[$];
		void'($urandom(47876));
		lit = 8'($urandom);
		d = 10'($urandom);
		literal_value = lit;
		note(0, {lit[3:2], d});
		note(1, {4'h0, lit});
		run({16'h5000, 16'h0000, 16'h3000, 16'h1000 | d, 16'h6000, 16'h0004});
		a = {2'b00, d[9:8], 8'hff} + 12'h002;
		mem.dmem[{2'b00, d}] = 8'hff;
		mem.dmem[a] = 8'($urandom);
		note(0, a);
		note(1, {4'h0, mem.dmem[a]});
		run({16'h1000 | d, 16'h5001, 16'h0000, 16'h2000, 16'h4000, 16'h4000, 16'h6000, 16'h0006});
		for (k = 0; k < 21; k++)
		begin
			f = 5'(k < 18 ? k : 0);
			m = 2'(k < 18 ? 0 : k - 17);
			lit = 8'($urandom);
			uni = 8'($urandom);
			literal_value = lit;
			universal_value = uni;
			r = alu(f, uni, lit);
			b = m == 0 ? r : m == 1 ? {r[7:4], lit[3:0]} : m == 2 ? {lit[7:4], r[3:0]} : 8'h00;
			note(2, {4'h0, b});
			note(1, {4'h0, b});
			run({16'h5000, 16'h0000, 16'hc000, 16'hd000, 16'hc000 | f, 16'h5002, 16'h0000,
				16'hd000 | m, 16'h5003, 16'h0000, 16'h6000, 16'h000a});
		end
		literal_value = lit;
		branch({16'h5000, 16'h0000, 16'hc000, 16'hd000}, cw(4'h9, 3'h0, 3'h0), lit[7]);
		branch({16'h5000, 16'h0000, 16'hc000, 16'hd000}, cw(4'ha, 3'h0, 3'h0), !lit[7]);
		for (k = 0; k < 8; k++)
			branch({16'h5000, 16'h0000}, cw(k[0] ? 4'ha : 4'h9, 3'h3, k[2:0]), lit[k] ^ k[0]);
		for (k = 0; k < 2; k++)
		begin
			universal_value = lit ^ 8'(k);
			branch({16'h5000, 16'h0000, 16'hc000, 16'hd000, 16'h5002, 16'h0000, 16'hc00e,
				16'h0000}, cw(4'h9, 3'h2, 3'h0), k == 0);
		end
		for (k = 0; k < 3; k++)
		begin
			literal_value = k == 0 ? 8'hff : 8'h00;
			note(5, {11'h000, k != 1});
			branch({16'h5000, 16'h0000, k == 2 ? 16'hc00f : 16'hc00c, 16'h0000},
				cw(4'h9, 3'h1, 3'h0), k != 1);
		end
		branch({16'h0000}, 16'h6000, 1'b1);
		for (m = 0; m < 2; m++)
		begin
			pre.delete();
			for (k = 0; k < 16 + m; k++)
			begin
				pre.push_back(16'h7000);
				pre.push_back(16'(2 * k + 2));
			end
			note(3, {11'h000, m[0]});
			branch(pre, cw(4'h9, 3'h4, 3'h0), m[0]);
		end
		note(0, 12'h101);
		run({16'h1100, 16'h7000, 16'h000a, 16'h6000, 16'h0003, 16'h0000, 16'h0000, 16'h0000,
			16'h0000, 16'h0000, 16'h8000, 16'h0000, 16'h4000, 16'h4000, 16'h6000, 16'h000e});
		note(0, 12'h077);
		note(4, 12'h001);
		note(6, 12'hff0);
		run({16'hb001, 16'h6000, 16'h07f0, 16'h10aa, 16'h6000, 16'h0004});
		wrap_up();
	end
	// watchdog against a hung run
	initial
	begin
		repeat (40000) @(posedge clk_sys);
		miscompares++;
		wrap_up();
	end
endmodule : test_byte_cpu_execution_core
bind exec_core exec_core_props u_props (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
	.instr_word(instr_word), .instr_addr(instr_addr), .mem_rdata(mem_rdata),
	.literal_value(literal_value), .universal_value(universal_value), .data_addr(data_addr),
	.data_bus(data_bus), .alu_reg(alu_reg), .carry_flag(carry_flag),
	.stack_overflow(stack_overflow), .page_select(page_select));
